// [logic/pcw_top.sv]
// calibration wait registers and settle sequencer for the second pll
`timescale 1ns/1ns
module pcw_top
  import pcw_pkg::*;
#(
  parameter int CNT_W = 24,
  parameter int LOOP0_CYC = PCW_LOOP0_CYC,
  parameter int LOOP1_CYC = PCW_LOOP1_CYC,
  parameter int LOOP2_CYC = PCW_LOOP2_CYC,
  parameter int LOOP3_CYC = PCW_LOOP3_CYC,
  parameter int OSC0_CYC = PCW_OSC0_CYC,
  parameter int OSC1_CYC = PCW_OSC1_CYC,
  parameter int OSC2_CYC = PCW_OSC2_CYC,
  parameter int OSC3_CYC = PCW_OSC3_CYC,
  parameter int DELAY_CYC = PCW_DELAY_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic nvm_load_i,
  input wire logic [7:0] nvm_wait_ctrl_i,
  input wire logic [7:0] nvm_delay_ctrl_i,
  input wire logic cal_start_i,
  output logic busy_o,
  output logic delay_active_o,
  output logic osc_settle_o,
  output logic loop_settle_o,
  output logic cal_done_o
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks
  localparam int MAX_CNT = 2 ** CNT_W;
  if (CNT_W < 2 || CNT_W > 30) begin : g_bad_w
    $error("counter width out of range");
  end
  if (LOOP0_CYC < 1 || LOOP1_CYC < 1 || LOOP2_CYC < 1 || LOOP3_CYC < 1 ||
      OSC0_CYC < 1 || OSC1_CYC < 1 || OSC2_CYC < 1 || OSC3_CYC < 1 ||
      DELAY_CYC < 1) begin : g_bad_min
    $error("wait counts must be at least one");
  end
  if (LOOP3_CYC > MAX_CNT || OSC3_CYC > MAX_CNT || LOOP2_CYC > MAX_CNT ||
      OSC2_CYC > MAX_CNT || DELAY_CYC > MAX_CNT || LOOP1_CYC > MAX_CNT ||
      OSC1_CYC > MAX_CNT || LOOP0_CYC > MAX_CNT ||
      OSC0_CYC > MAX_CNT) begin : g_bad_max
    $error("wait counts exceed counter width");
  end

  ////////////////////////////////////////////////////////////////////////
  // wait lookups, reload value is the count less one
  function automatic logic [CNT_W-1:0] loop_load(input logic [1:0] code);
    int n;
    case (code)
      2'h0: n = LOOP0_CYC;
      2'h1: n = LOOP1_CYC;
      2'h2: n = LOOP2_CYC;
      default: n = LOOP3_CYC;
    endcase
    return CNT_W'(n - 1);
  endfunction

  function automatic logic [CNT_W-1:0] osc_load(input logic [1:0] code);
    int n;
    case (code)
      2'h0: n = OSC0_CYC;
      2'h1: n = OSC1_CYC;
      2'h2: n = OSC2_CYC;
      default: n = OSC3_CYC;
    endcase
    return CNT_W'(n - 1);
  endfunction

  localparam logic [CNT_W-1:0] DELAY_LOAD = CNT_W'(DELAY_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // register file
  logic [1:0] loop_code_reg, loop_code_next;
  logic [1:0] osc_code_reg, osc_code_next;
  logic delay_sel_reg, delay_sel_next;
  logic [7:0] rdata_reg, rdata_next;

  // writes from software, nvm load wins in the same cycle
  always_comb begin
    loop_code_next = loop_code_reg;
    osc_code_next = osc_code_reg;
    delay_sel_next = delay_sel_reg;
    if (nvm_load_i) begin
      loop_code_next = nvm_wait_ctrl_i[PCW_LOOP_CODE_LSB +: 2];
      osc_code_next = nvm_wait_ctrl_i[PCW_OSC_CODE_LSB +: 2];
      delay_sel_next = nvm_delay_ctrl_i[PCW_DELAY_BIT];
    end else if (wr_en_i && addr_i == PCW_WAIT_CTRL_ADDR) begin
      loop_code_next = wdata_i[PCW_LOOP_CODE_LSB +: 2];
      osc_code_next = wdata_i[PCW_OSC_CODE_LSB +: 2];
    end else if (wr_en_i && addr_i == PCW_DELAY_CTRL_ADDR) begin
      delay_sel_next = wdata_i[PCW_DELAY_BIT];
    end
    // read data, reserved bits read zero
    rdata_next = 8'h00;
    if (addr_i == PCW_WAIT_CTRL_ADDR) begin
      rdata_next[PCW_LOOP_CODE_LSB +: 2] = loop_code_reg;
      rdata_next[PCW_OSC_CODE_LSB +: 2] = osc_code_reg;
    end else if (addr_i == PCW_DELAY_CTRL_ADDR) begin
      rdata_next[PCW_DELAY_BIT] = delay_sel_reg;
    end
  end

  // register flops with documented reset values
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      loop_code_reg <= PCW_LOOP_CODE_RST;
      osc_code_reg <= PCW_OSC_CODE_RST;
      delay_sel_reg <= PCW_DELAY_RST;
      rdata_reg <= 8'h00;
    end else begin
      loop_code_reg <= loop_code_next;
      osc_code_reg <= osc_code_next;
      delay_sel_reg <= delay_sel_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // settle sequencer
  pcw_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic done_reg, done_next;

  // a start restarts from the top; each stage counts clk_i periods
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    done_next = 1'b0;
    if (cal_start_i) begin
      if (delay_sel_reg) begin
        state_next = PCW_DELAY;
        cnt_next = DELAY_LOAD;
      end else begin
        state_next = PCW_OSC;
        cnt_next = osc_load(osc_code_reg);
      end
    end else begin
      case (state_reg)
        PCW_IDLE: begin
          cnt_next = cnt_reg;
        end
        PCW_DELAY: begin
          if (cnt_reg == '0) begin
            state_next = PCW_OSC;
            cnt_next = osc_load(osc_code_reg);
          end else begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
        PCW_OSC: begin
          if (cnt_reg == '0) begin
            state_next = PCW_LOOP;
            cnt_next = loop_load(loop_code_reg);
          end else begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
        PCW_LOOP: begin
          if (cnt_reg == '0) begin
            state_next = PCW_IDLE;
            done_next = 1'b1;
          end else begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
        default: begin
          state_next = PCW_IDLE;
        end
      endcase
    end
  end

  // sequencer flops
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= PCW_IDLE;
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  // stage outputs
  assign busy_o = (state_reg != PCW_IDLE);
  assign delay_active_o = (state_reg == PCW_DELAY);
  assign osc_settle_o = (state_reg == PCW_OSC);
  assign loop_settle_o = (state_reg == PCW_LOOP);
  assign cal_done_o = done_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence stage_end_s(pcw_state_t st);
    state_reg == st && cnt_reg == '0 && !cal_start_i;
  endsequence

  loop_wait_load_a: assert property (
    stage_end_s(PCW_OSC) |=> state_reg == PCW_LOOP &&
      cnt_reg == loop_load($past(loop_code_reg)))
    else $error("loop wait loaded wrong count");

  count_step_a: assert property (
    state_reg != PCW_IDLE && cnt_reg != '0 && !cal_start_i |=>
      cnt_reg == $past(cnt_reg) - 1'b1 && state_reg == $past(state_reg))
    else $error("wait counter did not step by one");

  osc_wait_load_a: assert property (
    cal_start_i && !delay_sel_reg |=> state_reg == PCW_OSC &&
      cnt_reg == osc_load($past(osc_code_reg)))
    else $error("oscillator wait loaded wrong count");

  delay_load_a: assert property (
    cal_start_i && delay_sel_reg |=> state_reg == PCW_DELAY &&
      cnt_reg == DELAY_LOAD)
    else $error("extra delay not applied");

  delay_reserved_a: assert property (
    $past(addr_i) == PCW_DELAY_CTRL_ADDR |->
      rdata_o[7:1] == 7'h00 && rdata_o[0] == $past(delay_sel_reg))
    else $error("delay register read wrong");

  delay_to_osc_a: assert property (
    stage_end_s(PCW_DELAY) |=> state_reg == PCW_OSC &&
      cnt_reg == osc_load($past(osc_code_reg)))
    else $error("delay did not hand over to oscillator wait");

  done_pulse_a: assert property (
    stage_end_s(PCW_LOOP) |=> cal_done_o && !busy_o ##1 !cal_done_o)
    else $error("done pulse wrong");

  done_cause_a: assert property (
    cal_done_o |-> $past(state_reg) == PCW_LOOP && $past(cnt_reg) == '0)
    else $error("done without loop wait end");

endmodule

// [logic/pcw_pkg.sv]
// constants for the pll calibration wait control block
// Notes on behaviour
// - loop wait code picks 30us/300us/30ms/300ms, reset 0
// - waits counted in always-on clock periods
// - oscillator code picks 20us/400us/8ms/200ms, reset 1
// - delayed calibration bit adds 60 ms first
// - delay bit is bit 0, rest reserved
package pcw_pkg;
  // register offsets
  localparam logic [7:0] PCW_WAIT_CTRL_ADDR = 8'h85;
  localparam logic [7:0] PCW_DELAY_CTRL_ADDR = 8'h86;
  // field positions
  localparam int PCW_LOOP_CODE_LSB = 2;
  localparam int PCW_OSC_CODE_LSB = 0;
  localparam int PCW_DELAY_BIT = 0;
  // values after reset
  localparam logic [1:0] PCW_LOOP_CODE_RST = 2'h0;
  localparam logic [1:0] PCW_OSC_CODE_RST = 2'h1;
  localparam logic PCW_DELAY_RST = 1'b0;
  // clock rate of the always-on clock
  localparam int PCW_CLK_KHZ = 25000;
  // wait times as printed
  localparam int PCW_LOOP0_US = 30;
  localparam int PCW_LOOP1_US = 300;
  localparam int PCW_LOOP2_MS = 30;
  localparam int PCW_LOOP3_MS = 300;
  localparam int PCW_OSC0_US = 20;
  localparam int PCW_OSC1_US = 400;
  localparam int PCW_OSC2_MS = 8;
  localparam int PCW_OSC3_MS = 200;
  localparam int PCW_DELAY_MS = 60;
  // cycle counts derived from the rate
  localparam int PCW_LOOP0_CYC = PCW_LOOP0_US * PCW_CLK_KHZ / 1000;
  localparam int PCW_LOOP1_CYC = PCW_LOOP1_US * PCW_CLK_KHZ / 1000;
  localparam int PCW_LOOP2_CYC = PCW_LOOP2_MS * PCW_CLK_KHZ;
  localparam int PCW_LOOP3_CYC = PCW_LOOP3_MS * PCW_CLK_KHZ;
  localparam int PCW_OSC0_CYC = PCW_OSC0_US * PCW_CLK_KHZ / 1000;
  localparam int PCW_OSC1_CYC = PCW_OSC1_US * PCW_CLK_KHZ / 1000;
  localparam int PCW_OSC2_CYC = PCW_OSC2_MS * PCW_CLK_KHZ;
  localparam int PCW_OSC3_CYC = PCW_OSC3_MS * PCW_CLK_KHZ;
  localparam int PCW_DELAY_CYC = PCW_DELAY_MS * PCW_CLK_KHZ;
  // sequencer states
  typedef enum logic [1:0] {
    PCW_IDLE,
    PCW_DELAY,
    PCW_OSC,
    PCW_LOOP
  } pcw_state_t;
endpackage

// [tb/pcw_tb_top.sv]
// self-checking bench for the pll calibration wait control block
`timescale 1ns/1ns
module pcw_tb_top;
  import pcw_pkg::*;
  localparam int DLY = 7;
  localparam int OSC2 = 9;
  localparam int OSC3 = 10;
  localparam int LOOP2 = 5;
  localparam int LOOP3 = 6;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic wr_en_i = 1'b0;
  logic [7:0] wdata_i = 8'h00;
  logic nvm_load_i = 1'b0;
  logic [7:0] nvm_wait_ctrl_i = 8'h00;
  logic [7:0] nvm_delay_ctrl_i = 8'h00;
  logic cal_start_i = 1'b0;
  logic [7:0] rdata_o;
  logic busy_o, delay_active_o, osc_settle_o, loop_settle_o, cal_done_o;
  int errors = 0;
  int n_tests = 0;
  logic [7:0] w;

  // long codes shortened, the two short codes keep their real lengths
  pcw_top #(.LOOP2_CYC(LOOP2), .LOOP3_CYC(LOOP3), .OSC2_CYC(OSC2),
    .OSC3_CYC(OSC3), .DELAY_CYC(DLY)) dut (.clk_i(clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .wr_en_i(wr_en_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .nvm_load_i(nvm_load_i),
    .nvm_wait_ctrl_i(nvm_wait_ctrl_i), .nvm_delay_ctrl_i(nvm_delay_ctrl_i),
    .cal_start_i(cal_start_i), .busy_o(busy_o),
    .delay_active_o(delay_active_o), .osc_settle_o(osc_settle_o),
    .loop_settle_o(loop_settle_o), .cal_done_o(cal_done_o));

  always #20 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////
  // expectations
  function automatic logic [31:0] osc_len(input logic [1:0] c);
    case (c)
      2'h0: return PCW_OSC0_CYC;
      2'h1: return PCW_OSC1_CYC;
      2'h2: return OSC2;
      default: return OSC3;
    endcase
  endfunction
  function automatic logic [31:0] loop_len(input logic [1:0] c);
    case (c)
      2'h0: return PCW_LOOP0_CYC;
      2'h1: return PCW_LOOP1_CYC;
      2'h2: return LOOP2;
      default: return LOOP3;
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // one-cycle write strobe, then one idle cycle before the next request
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i = a;
    wdata_i = d;
    wr_en_i = 1'b1;
    @(negedge clk_i);
    wr_en_i = 1'b0;
    @(negedge clk_i);
  endtask

  // read data is registered, so look one cycle after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr_i = a;
    @(negedge clk_i);
    check(rdata_o, e);
  endtask

  // run one calibration, optionally restarting it mid-run
  task automatic cal(input logic d, input logic [1:0] oc, input logic [1:0] lc,
      input bit rs);
    logic [31:0] nd, no, nl, nk, bad, t;
    nd = 0;
    no = 0;
    nl = 0;
    nk = 0;
    bad = 0;
    t = 0;
    wr(8'h86, {7'($urandom), d});
    wr(8'h85, {4'($urandom), lc, oc});
    cal_start_i = 1'b1;
    @(negedge clk_i);
    cal_start_i = 1'b0;
    if (rs) begin
      repeat (2) @(negedge clk_i);
      cal_start_i = 1'b1;
      @(negedge clk_i);
      cal_start_i = 1'b0;
    end
    // sample every cycle until the done pulse has come and gone
    while (t < 30000) begin
      if (osc_settle_o === 1'b1 && nl != 0) bad = 1;
      if (delay_active_o === 1'b1 && (no != 0 || nl != 0)) bad = 1;
      if ((delay_active_o | osc_settle_o | loop_settle_o) !== busy_o) bad = 1;
      nd += (delay_active_o === 1'b1);
      no += (osc_settle_o === 1'b1);
      nl += (loop_settle_o === 1'b1);
      if (cal_done_o === 1'b1) begin
        nk++;
        check(busy_o, 8'h00);
      end
      @(negedge clk_i);
      t++;
      if (nk != 0 && cal_done_o === 1'b0) break;
    end
    check(nd, d ? DLY : 0);
    check(no, osc_len(oc));
    check(nl, loop_len(lc));
    check(nk, 8'h01);
    check(bad, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // watchdog
  // settle runs need about 76000 cycles, give up at 90000
  initial begin
    #3600000;
    errors++;
    conclude();
  end

  // main sequence
  initial begin
    void'($urandom(32'h7cd1d607));
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    rd(8'h85, 8'h01);
    rd(8'h86, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 20; i++) begin
      w = 8'($urandom);
      wr(8'h85, w);
      rd(8'h85, w & 8'h0f);
      wr(8'h86, w);
      rd(8'h86, w & 8'h01);
      wr(8'h87, w);
      rd(8'h87, 8'h00);
    end
    $display("test register access done");
    nvm_wait_ctrl_i = 8'($urandom);
    nvm_delay_ctrl_i = 8'($urandom) | 8'h01;
    // a bus write in the same cycle must lose to the load
    addr_i = 8'h85;
    wdata_i = ~nvm_wait_ctrl_i;
    wr_en_i = 1'b1;
    nvm_load_i = 1'b1;
    @(negedge clk_i);
    wr_en_i = 1'b0;
    nvm_load_i = 1'b0;
    @(negedge clk_i);
    rd(8'h85, nvm_wait_ctrl_i & 8'h0f);
    rd(8'h86, 8'h01);
    $display("test nonvolatile load done");
    // every code pair once, the delay bit set on half of them, both ways for each code
    for (int k = 0; k < 16; k++) begin
      cal(k[0] ^ k[3], k[1:0], k[3:2], 1'b0);
    end
    $display("test settle codes done");
    cal(1'b1, 2'h2, 2'h3, 1'b1);
    $display("test restart done");
    // reset in mid-run drops the sequence and the registers
    cal_start_i = 1'b1;
    @(negedge clk_i);
    cal_start_i = 1'b0;
    repeat (3) @(negedge clk_i);
    reset_i = 1'b1;
    @(negedge clk_i);
    check(busy_o, 8'h00);
    check(cal_done_o, 8'h00);
    check(rdata_o, 8'h00);
    reset_i = 1'b0;
    rd(8'h85, 8'h01);
    rd(8'h86, 8'h00);
    $display("test mid-run reset done");
    conclude();
  end
endmodule
